/* File: hw/io_isi_pkg.sv */
package io_isi_pkg;

    // ****************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] ISI_OFFSET    = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_MODE_LSB      = 0;   // [2:0] one-hot output mode
    localparam int ISI_DELAY_LSB      = 0;   // [2:0] stretch setting
    localparam int STAT_HISTORY_LSB   = 0;   // [2:0] last three bits
    localparam int STAT_PAD_BIT       = 3;
    localparam int STAT_OE_N_BIT      = 4;
    localparam int STAT_STRETCH_BIT   = 5;
    localparam int STAT_UNDERRUN_BIT  = 6;   // sticky, write one to clear
    localparam int STAT_EVENTS_LSB    = 8;   // [15:8] stretch event count

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int DELAY_WIDTH  = 3;
    localparam int EVENT_WIDTH  = 8;
    localparam logic [2:0] ISI_DELAY_RESET = 3'h0;
    localparam logic [2:0] HISTORY_RESET   = 3'h0;

    // ****************************************************************
    // Timing: pad clock cycles per serialized symbol
    // ****************************************************************
    localparam int SYMBOL_CYCLES_DEFAULT = 8;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_SDR       = 3'b001,
        MODE_DDR       = 3'b010,
        MODE_DDR_X2    = 3'b100
    } output_mode_e;

    localparam output_mode_e MODE_RESET = MODE_SDR;

    typedef enum logic [1:0] {
        PAD_STEADY  = 2'b01,
        PAD_STRETCH = 2'b10
    } pad_state_e;

endpackage

/* File: hw/symbol_tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module symbol_tick_divider #(
    parameter int PERIOD = 8
) (
    input  wire logic clock,
    input  wire logic nrst,
    output logic      tick
);

    // ****************************************************************
    // Free-running divider, one-cycle enable at the symbol boundary
    // ****************************************************************
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    initial begin
        if (PERIOD < 2) begin
            $error("symbol_tick_divider: PERIOD must be at least 2");
        end
    end
    typedef struct packed {
        logic [CW-1:0] count;
        logic          tick;
    } div_state_s;

    div_state_s state;
    div_state_s next_state;
    // Wrap on the last count; the registered tick pulses one cycle later
    always_comb begin
        next_state = state;
        next_state.tick = (state.count == LAST);
        if (state.count == LAST) begin
            next_state.count = '0;
        end else begin
            next_state.count = state.count + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule

`default_nettype wire

/* File: hw/two_entry_buffer.sv */
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    initial begin
        if (WIDTH < 1) begin
            $error("two_entry_buffer: WIDTH must be at least 1");
        end
    end

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic                  head;
        logic [1:0]            count;
        logic                  ready;
    } buf_state_s;

    buf_state_s state;
    buf_state_s next_state;
    logic       push;
    logic       pop;

    // ****************************************************************
    // Storage; ready is registered so the source sees a clean flop
    // ****************************************************************
    always_comb begin
        next_state = state;
        push = in_valid && state.ready;
        pop  = out_ready && (state.count != 2'd0);
        if (push) begin
            next_state.slot[state.head ^ state.count[0]] = in_data;
        end
        if (pop) begin
            next_state.head = ~state.head;
        end
        next_state.count = state.count + {1'b0, push} - {1'b0, pop};
        next_state.ready = (next_state.count != 2'd2);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '{slot: '0, head: 1'b0, count: 2'd0, ready: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign in_ready  = state.ready;
    assign out_valid = (state.count != 2'd0);
    assign out_data  = state.slot[state.head];

endmodule

`default_nettype wire

/* File: hw/io_output_isi_tristate_regs.sv */
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module io_output_isi_tristate_regs #(
    parameter int SYMBOL_CYCLES = io_isi_pkg::SYMBOL_CYCLES_DEFAULT
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        data_in,
    input  wire logic        data_valid,
    output logic             data_ready,
    input  wire logic        tristate_in,
    input  wire logic        strobe_phase_clock_a,
    input  wire logic        strobe_phase_clock_b,
    input  wire logic [2:0]  isi_delay_in,
    input  wire logic        isi_delay_load,
    output logic             pad_out,
    output logic             pad_oe_n
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The largest stretch (7 cycles) must end inside the next symbol,
    // otherwise a stretched bit would swallow its successor.
    initial begin
        if (SYMBOL_CYCLES <= (1 << io_isi_pkg::DELAY_WIDTH) - 1) begin
            $error("SYMBOL_CYCLES must exceed the largest stretch setting");
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        io_isi_pkg::output_mode_e mode;
        logic [2:0]               isi_delay;
        logic                     tristate_first;
        logic                     oe_n;
        io_isi_pkg::pad_state_e   pad_state;
        logic                     pad;
        logic                     cur_bit;
        logic [2:0]               stretch_cnt;
        logic [2:0]               history;
        logic                     underrun;
        logic [7:0]               events;
        logic [31:0]              rdata;
    } regs_state_s;

    regs_state_s state;
    regs_state_s next_state;

    // ****************************************************************
    // Symbol pacing and input buffering
    // ****************************************************************
    logic symbol_tick;
    logic buf_bit;
    logic buf_valid;

    symbol_tick_divider #(
        .PERIOD (SYMBOL_CYCLES)
    ) u_divider (
        .clock (clock),
        .nrst  (nrst),
        .tick  (symbol_tick)
    );

    // The buffer drains only at symbol boundaries, so a burst from the
    // core fills it and back-pressure reaches the source via data_ready.
    two_entry_buffer #(
        .WIDTH (1)
    ) u_buffer (
        .clock     (clock),
        .nrst      (nrst),
        .in_data   (data_in),
        .in_valid  (data_valid),
        .in_ready  (data_ready),
        .out_data  (buf_bit),
        .out_valid (buf_valid),
        .out_ready (symbol_tick)
    );

    // ****************************************************************
    // Combinational helpers
    // ****************************************************************
    logic       gearing;
    logic       phase_step;
    logic       new_bit;
    logic [2:0] new_history;
    logic       isolated;
    logic [31:0] read_value;

    // Gearing decode and phase stepping of the second tristate flop
    always_comb begin
        gearing    = (state.mode == io_isi_pkg::MODE_DDR_X2);
        phase_step = strobe_phase_clock_a || strobe_phase_clock_b;
    end

    // Next symbol: buffered bit, or repeat of the last one on underrun
    always_comb begin
        new_bit     = buf_valid ? buf_bit : state.cur_bit;
        new_history = {state.history[1:0], new_bit};
        // Isolated middle bit: 010 or 101; runs never match
        isolated    = (new_history == 3'b010)
                   || (new_history == 3'b101);
    end

    // Read mux; unmapped and misaligned words read as zero
    always_comb begin
        read_value = 32'h0000_0000;
        case (reg_addr)
            io_isi_pkg::CTRL_OFFSET: begin
                read_value[io_isi_pkg::CTRL_MODE_LSB +: 3] = state.mode;
            end
            io_isi_pkg::ISI_OFFSET: begin
                read_value[io_isi_pkg::ISI_DELAY_LSB +: 3] = state.isi_delay;
            end
            io_isi_pkg::STATUS_OFFSET: begin
                read_value[io_isi_pkg::STAT_HISTORY_LSB +: 3] = state.history;
                read_value[io_isi_pkg::STAT_PAD_BIT]          = state.pad;
                read_value[io_isi_pkg::STAT_OE_N_BIT]         = state.oe_n;
                read_value[io_isi_pkg::STAT_STRETCH_BIT] =
                    (state.pad_state == io_isi_pkg::PAD_STRETCH);
                read_value[io_isi_pkg::STAT_UNDERRUN_BIT]     = state.underrun;
                read_value[io_isi_pkg::STAT_EVENTS_LSB +: 8]  = state.events;
            end
            default: begin
                read_value = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_state = state;

        // Read data stands in the cycle after the strobe only
        next_state.rdata = reg_read ? read_value : 32'h0000_0000;

        // Mode register; values that are not one-hot are ignored
        if (reg_write && (reg_addr == io_isi_pkg::CTRL_OFFSET)) begin
            case (reg_wdata[io_isi_pkg::CTRL_MODE_LSB +: 3])
                io_isi_pkg::MODE_SDR: begin
                    next_state.mode = io_isi_pkg::MODE_SDR;
                end
                io_isi_pkg::MODE_DDR: begin
                    next_state.mode = io_isi_pkg::MODE_DDR;
                end
                io_isi_pkg::MODE_DDR_X2: begin
                    next_state.mode = io_isi_pkg::MODE_DDR_X2;
                end
                default: begin
                    next_state.mode = state.mode;
                end
            endcase
        end

        // Per-pin stretch setting; the strobe control load wins over
        // a software write in the same cycle
        if (isi_delay_load) begin
            next_state.isi_delay = isi_delay_in;
        end else if (reg_write && (reg_addr == io_isi_pkg::ISI_OFFSET)) begin
            next_state.isi_delay = reg_wdata[io_isi_pkg::ISI_DELAY_LSB +: 3];
        end

        // Tristate path: first flop always samples the core enable
        next_state.tristate_first = tristate_in;
        if (gearing) begin
            // Second flop, advanced on either strobe phase
            if (phase_step) begin
                next_state.oe_n = state.tristate_first;
            end
        end else begin
            // Single flop straight to the buffer enable
            next_state.oe_n = tristate_in;
        end

        // Underrun sticky: write one clears, a new underrun wins
        if (reg_write && (reg_addr == io_isi_pkg::STATUS_OFFSET)
            && reg_wdata[io_isi_pkg::STAT_UNDERRUN_BIT]) begin
            next_state.underrun = 1'b0;
        end
        if (symbol_tick && !buf_valid) begin
            next_state.underrun = 1'b1;
        end

        // Data path: stretch countdown within the current symbol
        case (state.pad_state)
            io_isi_pkg::PAD_STEADY: begin
                next_state.pad = state.cur_bit;
            end
            io_isi_pkg::PAD_STRETCH: begin
                // Hold the previous level until the count runs out
                if (state.stretch_cnt == 3'd1) begin
                    next_state.pad_state   = io_isi_pkg::PAD_STEADY;
                    next_state.stretch_cnt = 3'd0;
                    next_state.pad         = state.cur_bit;
                end else begin
                    next_state.stretch_cnt = state.stretch_cnt - 3'd1;
                end
            end
            default: begin
                next_state.pad_state   = io_isi_pkg::PAD_STEADY;
                next_state.stretch_cnt = 3'd0;
            end
        endcase

        // Symbol boundary: shift history, decide on stretching
        if (symbol_tick) begin
            next_state.cur_bit = new_bit;
            next_state.history = new_history;
            if (gearing && isolated && (state.isi_delay != 3'd0)) begin
                // Extend the isolated bit into the next symbol
                next_state.pad_state   = io_isi_pkg::PAD_STRETCH;
                next_state.stretch_cnt = state.isi_delay;
                next_state.pad         = state.cur_bit;
                next_state.events      = state.events + 8'd1;
            end else begin
                // Runs and non-gearing modes switch on the boundary
                next_state.pad_state   = io_isi_pkg::PAD_STEADY;
                next_state.stretch_cnt = 3'd0;
                next_state.pad         = new_bit;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Pad released (oe_n high) from reset until the core drives it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '{
                mode:        io_isi_pkg::MODE_RESET,
                isi_delay:   io_isi_pkg::ISI_DELAY_RESET,
                tristate_first: 1'b1,
                oe_n:        1'b1,
                pad_state:   io_isi_pkg::PAD_STEADY,
                pad:         1'b0,
                cur_bit:     1'b0,
                stretch_cnt: 3'd0,
                history:     io_isi_pkg::HISTORY_RESET,
                underrun:    1'b0,
                events:      8'd0,
                rdata:       32'h0000_0000
            };
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs, each straight from a state flop
    // ****************************************************************
    assign reg_rdata = state.rdata;
    assign pad_out   = state.pad;
    assign pad_oe_n  = state.oe_n;

endmodule

`default_nettype wire

/* File: tb/io_isi_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checker for the output cell
// ****************************************
module io_isi_checker #(
    parameter int SYMBOL_CYCLES = 8
) (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        data_in,
    input wire logic        data_valid,
    input wire logic        data_ready,
    input wire logic        tristate_in,
    input wire logic        strobe_phase_clock_a,
    input wire logic        strobe_phase_clock_b,
    input wire logic [2:0]  isi_delay_in,
    input wire logic        isi_delay_load,
    input wire logic        pad_out,
    input wire logic        pad_oe_n
);
    logic [2:0] mode;
    logic [2:0] isi;
    logic [3:0] quiet;
    wire        settled = (quiet >= 4'hc);
    // Shadow of mode and setting; a stretch may outlive a mode change
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode  <= 3'h1;
            isi   <= 3'h0;
            quiet <= 4'hf;
        end else begin
            if (reg_write && reg_addr == 4'h0 && $onehot(reg_wdata[2:0])) begin
                mode <= reg_wdata[2:0];
            end
            if (isi_delay_load) begin
                isi <= isi_delay_in;
            end else if (reg_write && reg_addr == 4'h4) begin
                isi <= reg_wdata[2:0];
            end
            quiet <= (mode == 3'h4) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Enable path, one flop or two by mode
    AST_OE_SINGLE: assert property (mode != 3'h4 |=> pad_oe_n == $past(tristate_in))
        else $error("enable not one cycle behind core control");
    AST_OE_X2_HOLD: assert property (
        mode == 3'h4 && !strobe_phase_clock_a && !strobe_phase_clock_b |=> $stable(pad_oe_n))
        else $error("enable moved without a phase pulse");
    AST_OE_X2_STEP: assert property (
        mode == 3'h4 && (strobe_phase_clock_a || strobe_phase_clock_b) && $past(nrst)
        |=> pad_oe_n == $past(tristate_in, 2))
        else $error("enable not two flops behind core control");
    // Register port answers
    AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    AST_UNMAPPED: assert property (reg_read && reg_addr != 4'h0 && reg_addr != 4'h4
        && reg_addr != 4'h8 |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_CTRL_READ: assert property (reg_read && reg_addr == 4'h0 |=> reg_rdata == {29'h0, mode})
        else $error("mode readback wrong");
    AST_ISI_READ: assert property (
        reg_read && reg_addr == 4'h4 |=> reg_rdata == {29'h0, isi})
        else $error("stretch setting readback wrong");
    // Outside gearing mode nothing stretches
    AST_NO_STRETCH: assert property (
        settled && reg_read && reg_addr == 4'h8 |=> !reg_rdata[5])
        else $error("stretch flag set outside gearing mode");
    AST_PAD_STEADY: assert property (
        settled && $changed(pad_out) |=> $stable(pad_out)[*7])
        else $error("pad moved within one symbol");
    COV_PHASE_B: cover property (mode == 3'h4 && strobe_phase_clock_b);
    COV_REFUSE: cover property (data_valid && !data_ready);
    COV_LONG_SET: cover property (mode == 3'h4 && isi == 3'h7 && $changed(pad_out));
endmodule

bind io_output_isi_tristate_regs io_isi_checker #(.SYMBOL_CYCLES(SYMBOL_CYCLES)) i_io_isi_checker (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .data_in(data_in), .data_valid(data_valid), .data_ready(data_ready),
    .tristate_in(tristate_in), .strobe_phase_clock_a(strobe_phase_clock_a),
    .strobe_phase_clock_b(strobe_phase_clock_b), .isi_delay_in(isi_delay_in),
    .isi_delay_load(isi_delay_load), .pad_out(pad_out), .pad_oe_n(pad_oe_n));
`default_nettype wire

/* File: tb/core_fabric_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Core side bit source, pattern bit length-1 first, down to bit 0
// ****************************************
module core_fabric_model (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic [15:0] pattern,
    input  wire logic [4:0]  length,
    input  wire logic [1:0]  gap,
    input  wire logic        data_ready,
    output logic             data_in,
    output logic             data_valid,
    output logic             busy
);
    logic [4:0] left;
    logic [1:0] pause;
    assign busy = (left != 5'h00);
    // Offer held until taken; gap paces a slow source
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            left       <= 5'h00;
            pause      <= 2'h0;
            data_valid <= 1'b0;
            data_in    <= 1'b0;
        end else if (start) begin
            left  <= length;
            pause <= 2'h0;
        end else if (data_valid && data_ready) begin
            left       <= left - 5'h01;
            pause      <= gap;
            data_valid <= (gap == 2'h0) && (left > 5'h01);
            data_in    <= (gap == 2'h0 && left > 5'h01) ? pattern[left - 5'h02] : ~data_in;
        end else if (!data_valid && busy && pause == 2'h0) begin
            data_valid <= 1'b1;
            data_in    <= pattern[left - 5'h01];
        end else if (!data_valid) begin
            // Released line must not look like a stale bit
            pause   <= (pause == 2'h0) ? pause : pause - 2'h1;
            data_in <= ~data_in;
        end
    end
endmodule
`default_nettype wire

/* File: tb/test_io_output_isi_tristate_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end end
// ****************************************
// Bench for the output cell
// ****************************************
module test_io_output_isi_tristate_regs;
    localparam int SYM = 8;
    logic        clock     = 1'b0;
    logic        nrst      = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [31:0] reg_rdata;
    logic        data_in;
    logic        data_valid;
    logic        data_ready;
    logic        tristate_in = 1'b1;
    logic        phase_a     = 1'b0;
    logic        phase_b     = 1'b0;
    logic [2:0]  isi_in      = 3'h0;
    logic        isi_load    = 1'b0;
    logic        pad_out;
    logic        pad_oe_n;
    logic        start       = 1'b0;
    logic [15:0] pattern     = 16'h0000;
    logic [4:0]  length      = 5'h00;
    logic [1:0]  gap         = 2'h0;
    logic        busy;
    logic [31:0] d;
    int          fail_count  = 0;
    int          checked     = 0;
    int          events      = 0;
    always #2.5 clock = ~clock;
    io_output_isi_tristate_regs #(.SYMBOL_CYCLES(SYM)) i_io_output_isi_tristate_regs (
        .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .data_in(data_in), .data_valid(data_valid), .data_ready(data_ready),
        .tristate_in(tristate_in), .strobe_phase_clock_a(phase_a),
        .strobe_phase_clock_b(phase_b), .isi_delay_in(isi_in), .isi_delay_load(isi_load),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n));
    core_fabric_model i_core_fabric_model (
        .clock(clock), .nrst(nrst), .start(start), .pattern(pattern), .length(length),
        .gap(gap), .data_ready(data_ready), .data_in(data_in), .data_valid(data_valid),
        .busy(busy));
    // ****************************************
    // Bus and wait helpers
    // ****************************************
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        v = reg_rdata;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(v, e);
    endtask
    // Bounded wait; running out ends the run as a failure
    task automatic wait_for(ref logic sig, input logic lvl);
        for (int i = 0; i < 400; i++) begin
            if (sig === lvl) begin
                return;
            end
            @(posedge clock);
        end
        fail_count++;
        tally_and_finish();
    endtask
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (pad_out === lvl && n < 400) begin
            n++;
            @(posedge clock);
        end
    endtask
    // Load pulse and bus write in one cycle: the pulse must win
    task automatic set_isi(input logic [2:0] s, input logic ld);
        if (ld) begin
            @(posedge clock);
            reg_addr  <= 4'h4;
            reg_wdata <= {29'h0, ~s};
            reg_write <= 1'b1;
            isi_in    <= s;
            isi_load  <= 1'b1;
            @(posedge clock);
            reg_write <= 1'b0;
            isi_load  <= 1'b0;
        end else begin
            wr(4'h4, {29'h0, s});
        end
        rdchk(4'h4, {29'h0, s});
    endtask
    task automatic x2_step(input logic t, input logic use_b);
        @(posedge clock);
        tristate_in <= t;
        repeat (4) @(posedge clock);
        `CHK(pad_oe_n, ~t);
        phase_a <= !use_b;
        phase_b <= use_b;
        @(posedge clock);
        phase_a <= 1'b0;
        phase_b <= 1'b0;
        @(posedge clock);
        `CHK(pad_oe_n, t);
    endtask
    // Isolated bit after a run; width of the isolated bit is measured
    task automatic pulse_case(input logic [2:0] m, input logic [2:0] s, input logic ld,
                              input logic lvl, input logic [1:0] g, input int exp);
        int w;
        wr(4'h0, {29'h0, m});
        set_isi(s, ld);
        @(posedge clock);
        pattern <= lvl ? 16'h0008 : 16'h0077;
        length  <= 5'h0a;
        gap     <= g;
        start   <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        wait_for(data_ready, 1'b0);
        wr(4'h8, 32'h0000_0040);
        rd(4'h8, d);
        `CHK(d[6], 1'b0);
        wait_for(pad_out, 1'b0);
        wait_for(pad_out, 1'b1);
        run_len(1'b1, w);
        if (!lvl) begin
            `CHK(w, 3 * SYM);
            run_len(1'b0, w);
        end
        `CHK(w, exp);
        events += (m == 3'h4 && s != 3'h0) ? 1 : 0;
        wait_for(busy, 1'b0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clock);
        `CHK(pad_oe_n, 1'b1);
        `CHK(data_ready, 1'b1);
        `CHK(pad_out, 1'b0);
        nrst <= 1'b1;
        rdchk(4'h0, 32'h0000_0001);
        rdchk(4'h4, 32'h0000_0000);
        rdchk(4'hc, 32'h0000_0000);
        rdchk(4'h2, 32'h0000_0000);
        // Single rate enable, then gearing mode; bad mode code ignored
        @(posedge clock);
        tristate_in <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(pad_oe_n, 1'b0);
        wr(4'h0, 32'h0000_0004);
        wr(4'h0, 32'h0000_0003);
        rdchk(4'h0, 32'h0000_0004);
        x2_step(1'b1, 1'b0);
        x2_step(1'b0, 1'b1);
        // Modes, settings and pacing across the stretch cases
        pulse_case(3'h1, 3'h3, 1'b1, 1'b1, 2'h0, SYM);
        pulse_case(3'h2, 3'h5, 1'b0, 1'b0, 2'h0, SYM);
        pulse_case(3'h4, 3'h0, 1'b0, 1'b1, 2'h0, SYM);
        pulse_case(3'h4, 3'h7, 1'b1, 1'b0, 2'h1, SYM + 7);
        pulse_case(3'h4, 3'h3, 1'b0, 1'b1, 2'h0, SYM + 3);
        pulse_case(3'h4, 3'h1, 1'b1, 1'b0, 2'h2, SYM + 1);
        // Buffer drains, then underrun, history and event count
        repeat (5 * SYM) @(posedge clock);
        rd(4'h8, d);
        `CHK(d & 32'h0000_ffef, {16'h0000, events[7:0], 8'h4f});
        tally_and_finish();
    end
endmodule
`default_nettype wire
